// ==== bench/swf_chk_props.sv ====
// Checks on the formatter's beat stream and request handshake.
// Assumes it is bound to swf_writeback_formatter and sees only its ports.
`timescale 1ns/10ps
module swf_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic wbValid,
    input wire logic wbReady,
    input wire logic [7:0] wbDestReg,
    input wire logic [7:0] wbDwordEn,
    input wire logic [255:0] wbData,
    input wire logic wbLast,
    input wire logic [1:0] wbLayout
);
    logic [3:0] idx_reg;
    logic [7:0] prev_reg;
    logic s8, s16, s42, sun;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    assign s8 = wbValid && wbLayout == swf_pkg::LAY_SIMD8;
    assign s16 = wbValid && wbLayout == swf_pkg::LAY_SIMD16;
    assign s42 = wbValid && wbLayout == swf_pkg::LAY_SIMD4X2;
    assign sun = wbValid && wbLayout == swf_pkg::LAY_UNORM;
    // Beat index within the current response
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idx_reg <= 4'h0;
            prev_reg <= 8'h00;
        end else if (wbValid && wbReady) begin
            idx_reg <= wbLast ? 4'h0 : idx_reg + 4'h1;
            prev_reg <= wbDestReg;
        end
    end
    chk_req_busy: assert property (reqValid && reqReady |=> !reqReady)
        else $error("request taken while busy");
    chk_beat_hold: assert property (wbValid && !wbReady |=> wbValid && $stable(wbData))
        else $error("beat changed while stalled");
    chk_s16_count: assert property (s16 |-> idx_reg <= 4'h7)
        else $error("simd16 response too long");
    chk_dest_pack: assert property (
        (s16 || s8) && idx_reg != 4'h0 |-> wbDestReg == prev_reg + 8'h01)
        else $error("destination not consecutive");
    chk_s8_count: assert property (
        s8 |-> idx_reg < 4'h4 || (idx_reg == 4'h4 && wbLast))
        else $error("simd8 response too long");
    chk_s8_kill: assert property (
        s8 && idx_reg == 4'h4 |-> wbDwordEn == 8'h01 && wbData[31:8] == 24'hFFFFFF)
        else $error("simd8 kill register wrong");
    chk_4x2_single: assert property (s42 |-> wbLast && idx_reg == 4'h0)
        else $error("simd4x2 not one register");
    chk_unorm_kill: assert property (
        sun && wbDwordEn != 8'hFF |-> wbLast && wbDwordEn == 8'h01)
        else $error("unorm partial register wrong");
endmodule
bind swf_writeback_formatter swf_chk u_chk (.*);

// ==== bench/swf_rf.sv ====
// Destination register file model: accepts beats and logs them.
// Assumes valid/ready beats; slow makes it accept every other cycle.
`timescale 1ns/10ps
module swf_rf (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow,
    input wire logic wbValid,
    output logic wbReady,
    input wire logic [7:0] wbDestReg,
    input wire logic [7:0] wbDwordEn,
    input wire logic [255:0] wbData,
    input wire logic wbLast,
    input wire logic [1:0] wbLayout
);
    logic tog;
    int n;
    logic [7:0] dr [64];
    logic [7:0] de [64];
    logic [255:0] dd [64];
    logic [2:0] dl [64];
    assign wbReady = !slow || tog;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tog <= 1'b0;
            n <= 0;
        end else begin
            tog <= !tog;
            if (wbValid && wbReady) begin
                dr[n] <= wbDestReg;
                de[n] <= wbDwordEn;
                dd[n] <= wbData;
                dl[n] <= {wbLayout, wbLast};
                n <= n + 1;
            end
        end
    end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench of the writeback formatter.
// Assumes a 250 MHz clk_sys and the swf_rf model on the beat port.
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, reqValid = 1'b0;
    logic reqKill = 1'b0, reqRedGreen = 1'b0, slow = 1'b0;
    logic [1:0] htrans = 2'h0, reqLayout = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] reqChanMask = 4'h0;
    logic [15:0] reqExecMask = 16'h0000;
    logic [7:0] reqDestBase = 8'h10;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, reqKillMask = 32'h0, rd;
    logic [2047:0] reqData;
    logic hreadyout, hresp, reqReady, wbValid, wbReady, wbLast;
    logic [31:0] hrdata;
    logic [7:0] wbDestReg, wbDwordEn;
    logic [255:0] wbData;
    logic [1:0] wbLayout;
    int n_errors = 0, checks = 0, n0;
    always #2 clk_sys = !clk_sys;
    swf_writeback_formatter dut (.hready(hreadyout), .*);
    swf_rf rf (.*);
    task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic guard(inout int t);
        @(negedge clk_sys);
        t++;
        if (t > 200) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int t = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= swf_pkg::HTRANS_NONSEQ;
        do guard(t); while (hreadyout !== 1'b1);
        @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do guard(t); while (hreadyout !== 1'b1);
        @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic send(input logic [1:0] ly, input logic [3:0] cm, input logic [15:0] em,
                        input logic kl, input logic rg, input logic [31:0] km, input int nb);
        int t = 0;
        n0 = rf.n;
        @(posedge clk_sys);
        reqLayout <= ly;
        reqChanMask <= cm;
        reqExecMask <= em;
        reqKill <= kl;
        reqRedGreen <= rg;
        reqKillMask <= km;
        reqValid <= 1'b1;
        do guard(t); while (reqReady !== 1'b1);
        @(posedge clk_sys);
        reqValid <= 1'b0;
        t = 0;
        do guard(t); while (rf.n < n0 + nb || t < 40);
        chk("beats", 256'(rf.n - n0), 256'(nb));
        chk("tail", 256'(rf.dl[rf.n - 1]), 256'({ly, 1'b1}));
    endtask
    function automatic logic [255:0] msk(input logic [7:0] e);
        for (int d = 0; d < 8; d++)
            msk[d*32 +: 32] = {32{e[d]}};
    endfunction
    task automatic beat(input int k, input logic [7:0] d, input logic [7:0] e,
                        input logic [255:0] v);
        chk("dest", 256'(rf.dr[n0+k]), 256'(d));
        chk("enable", 256'(rf.de[n0+k]), 256'(e));
        chk("data", rf.dd[n0+k] & msk(e), v & msk(e));
    endtask
    task automatic t_regs();
        ahb(1'b0, 32'h54, 32'h0);
        chk("lut", 256'(rd[4:0]), 256'h5);
        ahb(1'b1, 32'h54, 32'h1F);
        ahb(1'b0, 32'h54, 32'h0);
        chk("lut write", 256'(rd[4:0]), 256'h1F);
        ahb(1'b1, 32'h54, 32'h5);
        ahb(1'b1, 32'h0, 32'h2);
        ahb(1'b0, 32'h0, 32'h0);
        chk("format", 256'(rd[1:0]), 256'h2);
        ahb(1'b0, 32'h100, 32'h0);
        chk("unmapped", 256'(rd), 256'h0);
    endtask
    task automatic t_4x2();
        @(posedge clk_sys);
        reqData[63:32] <= 32'h4120_0000;
        send(2'h2, 4'h8, 16'h0010, 1'b0, 1'b0, 32'h0, 1);
        beat(0, 8'h10, 8'h70, {96'h0, 32'hA, 128'h0});
        ahb(1'b1, 32'h0, 32'h0);
    endtask
    task automatic t_s16();
        slow <= 1'b1;
        send(2'h0, 4'h6, 16'h0FF0, 1'b0, 1'b0, 32'h0, 4);
        slow <= 1'b0;
        beat(0, 8'h10, 8'hF0, reqData[255:0]);
        beat(1, 8'h11, 8'h0F, reqData[511:256]);
        beat(2, 8'h12, 8'hF0, reqData[1791:1536]);
        beat(3, 8'h13, 8'h0F, reqData[2047:1792]);
    endtask
    task automatic t_s8();
        send(2'h1, 4'h2, 16'h00F0, 1'b1, 1'b0, 32'h3, 5);
        for (int k = 0; k < 4; k++)
            beat(k, 8'h10 + 8'(k), k == 1 ? 8'h00 : 8'hF0, reqData[k*512 +: 256]);
        beat(4, 8'h14, 8'h01, {224'h0, 32'hFFFF_FFFC});
    endtask
    task automatic t_unorm(input logic rg, input logic [3:0] cm, input int nb, input int ki);
        int lo[8] = '{0, 2, 8, 10, 4, 6, 12, 14};
        int k = 0;
        logic [255:0] v;
        send(2'h3, cm, 16'h0, 1'b1, rg, 32'h8000_0001, nb);
        for (int c = 0; c < 4; c++)
            if (!cm[c] && !(rg && c > 1))
                for (int h = 0; h < 2; h++) begin
                    for (int d = 0; d < 8; d++)
                        v[d*32 +: 32] = reqData[c*512 + (lo[d] + 16*h)*16 +: 32];
                    beat(k, 8'h10 + 8'(k), 8'hFF, v);
                    k++;
                end
        beat(k, 8'h10 + 8'(ki), 8'h01, {224'h0, 32'h7FFF_FFFE});
    endtask
    initial begin
        for (int i = 0; i < 64; i++)
            reqData[i*32 +: 32] = {8'h3F, 8'(i), 8'h20, 8'(i)};
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_4x2();
        t_s16();
        t_s8();
        t_unorm(1'b1, 4'h1, 3, 4);
        t_unorm(1'b0, 4'h4, 7, 6);
        finish_test();
    end
endmodule

// ==== rtl/swf_beat_buf.sv ====
// Small FIFO that holds writeback beats while the register file stalls.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/10ps
module swf_beat_buf #(
    parameter int DEPTH = 2,
    parameter int W = swf_pkg::BEAT_W
) (
    input wire logic clk,
    input wire logic rstn,
    swf_beat_if.dst inp,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outWord
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        if (p == LAST) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    assign inp.ready = (count_reg != FULL);
    assign outValid = (count_reg != '0);
    assign push = inp.valid && inp.ready;
    assign pop = outValid && outReady;
    assign outWord = mem[rdPtr_reg];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= {inp.layout, inp.last, inp.destReg, inp.dwordEn, inp.data};
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= bump(wrPtr_reg);
            end
            if (pop) begin
                rdPtr_reg <= bump(rdPtr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ==== rtl/swf_beat_if.sv ====
// One destination-register beat between formatter and its output buffer.
// Assumes both ends share clk_sys.
`timescale 1ns/10ps
interface swf_beat_if;
    logic valid;
    logic ready;
    logic [255:0] data;
    logic [7:0] dwordEn;
    logic [7:0] destReg;
    logic last;
    logic [1:0] layout;
    modport src(output valid, data, dwordEn, destReg, last, layout, input ready);
    modport dst(input valid, data, dwordEn, destReg, last, layout, output ready);
endinterface

// ==== rtl/swf_mask_lut.sv ====
// Programmable map from active-mask bit to block pixel number.
// Assumes writes come from the register bus slave of the top module.
`timescale 1ns/10ps
module swf_mask_lut #(
    parameter int N = swf_pkg::LUT_N
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [4:0] wrIdx,
    input wire logic [4:0] wrVal,
    input wire logic [4:0] rdIdx,
    output logic [4:0] rdVal,
    input wire logic [N-1:0] killMask,
    output logic [N-1:0] activeMask
);
    logic [4:0] map_reg [N];

    assign rdVal = map_reg[rdIdx];

    // Identity mapping after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                map_reg[i] <= 5'(i);
            end
        end else if (wrEn) begin
            map_reg[wrIdx] <= wrVal;
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            activeMask[i] = !killMask[map_reg[i]];
        end
    end
endmodule

// ==== rtl/swf_pkg.sv ====
// Constants, types and register map of the sampler writeback formatter.
// Assumes a 32-bit AHB-Lite register bus and 32-bit destination dwords.
package swf_pkg;
    typedef enum logic [1:0] {
        LAY_SIMD16 = 2'h0,
        LAY_SIMD8 = 2'h1,
        LAY_SIMD4X2 = 2'h2,
        LAY_UNORM = 2'h3
    } swf_layout_e;
    typedef enum logic [1:0] {
        FMT_FLOAT = 2'h0,
        FMT_SINT = 2'h1,
        FMT_UINT = 2'h2
    } swf_fmt_e;
    localparam int CHAN_W = 512;
    localparam int DW_W = 32;
    localparam int HALF_W = 16;
    localparam int REG_DW = 8;
    localparam int REQ_W = 2048;
    localparam int BEAT_W = 275;
    localparam int LUT_N = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_LUT = 8'h40;
    localparam logic [7:0] OFF_LUT_END = 8'hC0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [15:0] DISPATCH_MASK = 16'hFFFF;
    localparam logic [7:0] SIMD8_PAD = 8'hFF;
    localparam logic [7:0] KILL_DW_EN = 8'h01;
    localparam logic [7:0] ALL_DW_EN = 8'hFF;
    localparam logic [3:0] RG_FORCE_MASK = 4'hC;
    localparam logic [3:0] RG_KILL_IDX = 4'h4;
    localparam logic [3:0] SIMD8_REGS = 4'h4;
    localparam logic [2:0] SLOT_MAX_PAIR = 3'h7;
    localparam logic [2:0] SLOT_MAX_SIMD8 = 3'h3;
    localparam logic [2:0] SLOT_MAX_4X2 = 3'h0;
    localparam logic [4:0] HALF_PIX = 5'h10;
    // Low pixel of the pair held by each unorm dword, dword 0 in the low bits
    localparam logic [39:0] PAIR_TABLE = {5'h0E, 5'h0C, 5'h06, 5'h04,
                                          5'h0A, 5'h08, 5'h02, 5'h00};
    localparam logic [7:0] FLOAT_BIAS = 8'h7F;
    localparam logic [7:0] INT_SAT_EXP = 8'h20;
    localparam logic [31:0] S31_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] S31_MIN = 32'h8000_0001;
endpackage

// ==== rtl/swf_writeback_formatter.sv ====
// Writeback formatter of the texture sampler: turns one sampled request
// into the destination-register beats of its response message.
// Assumes an upstream filter delivering all channel values at once and a
// register file that accepts beats by valid/ready; AHB-Lite for control.
`timescale 1ns/10ps
module swf_writeback_formatter (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [1:0] reqLayout,
    input wire logic [3:0] reqChanMask,
    input wire logic [15:0] reqExecMask,
    input wire logic reqKill,
    input wire logic reqRedGreen,
    input wire logic [7:0] reqDestBase,
    input wire logic [31:0] reqKillMask,
    input wire logic [2047:0] reqData,
    output logic wbValid,
    input wire logic wbReady,
    output logic [7:0] wbDestReg,
    output logic [7:0] wbDwordEn,
    output logic [255:0] wbData,
    output logic wbLast,
    output logic [1:0] wbLayout
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EMIT = 3'b010,
        ST_KILL = 3'b100
    } swf_state_e;
    logic rstn, kill_reg, rg_reg, apValid_reg, apWrite_reg, apLow_reg, lutHit, beatOn, half;
    logic accept, advance;
    logic [1:0] rstPipe_reg, fmtLatch_reg, fmt_reg, chan;
    logic [2:0] slot_reg, slotMax;
    logic [3:0] mask_reg, outCnt_reg, total_reg, maskEff;
    logic [4:0] lutRd, activeLutVal;
    logic [7:0] base_reg, apAddr_reg, lutOff, beatEn;
    logic [15:0] exec_reg, respCount_reg;
    logic [31:0] killMask_reg, activeMask;
    logic [255:0] beatData;
    logic [2047:0] data_reg;
    logic [swf_pkg::BEAT_W-1:0] outWord;
    swf_state_e state_reg;
    swf_pkg::swf_layout_e lay_reg;
    swf_beat_if beat ();

    function automatic logic [31:0] pix32(input logic [2047:0] d, input logic [1:0] c,
                                          input logic [3:0] p);
        return d[int'(c) * swf_pkg::CHAN_W + int'(p) * swf_pkg::DW_W +: swf_pkg::DW_W];
    endfunction
    function automatic logic [15:0] pix16(input logic [2047:0] d, input logic [1:0] c,
                                          input logic [4:0] p);
        return d[int'(c) * swf_pkg::CHAN_W + int'(p) * swf_pkg::HALF_W +: swf_pkg::HALF_W];
    endfunction
    // Float value recast as signed or unsigned integer, truncating
    function automatic logic [31:0] fmtVal(input logic [31:0] f, input logic [1:0] sel);
        logic [7:0] ex;
        logic [54:0] wide;
        logic [31:0] mag;
        ex = f[30:23];
        wide = '0;
        mag = '0;
        if (ex >= swf_pkg::FLOAT_BIAS + swf_pkg::INT_SAT_EXP) begin
            mag = 32'hFFFF_FFFF;
        end else if (ex >= swf_pkg::FLOAT_BIAS) begin
            wide = {31'h0, 1'b1, f[22:0]} << (ex - swf_pkg::FLOAT_BIAS);
            mag = wide[54:23];
        end
        case (sel)
            swf_pkg::FMT_UINT: begin
                fmtVal = f[31] ? '0 : mag;
            end
            swf_pkg::FMT_SINT: begin
                if (mag > swf_pkg::S31_MAX) begin
                    fmtVal = f[31] ? swf_pkg::S31_MIN : swf_pkg::S31_MAX;
                end else begin
                    fmtVal = f[31] ? 32'h0 - mag : mag;
                end
            end
            default: begin
                fmtVal = f;
            end
        endcase
    endfunction
    function automatic logic [3:0] regCount(input logic [1:0] lay, input logic [3:0] m,
                                            input logic k);
        logic [3:0] on;
        on = 4'(!m[0]) + 4'(!m[1]) + 4'(!m[2]) + 4'(!m[3]);
        case (lay)
            swf_pkg::LAY_SIMD8: begin
                regCount = swf_pkg::SIMD8_REGS + 4'(k);
            end
            swf_pkg::LAY_SIMD4X2: begin
                regCount = 4'h1;
            end
            default: begin
                regCount = 4'((on << 1) + 4'(k));
            end
        endcase
    endfunction
    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstn = rstPipe_reg[1];

    // Bus slave: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign lutOff = apAddr_reg - swf_pkg::OFF_LUT;
    assign lutHit = apLow_reg && apAddr_reg >= swf_pkg::OFF_LUT
                    && apAddr_reg < swf_pkg::OFF_LUT_END;
    assign lutRd = lutOff[6:2];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            apValid_reg <= 1'b0;
            apWrite_reg <= 1'b0;
            apLow_reg <= 1'b0;
            apAddr_reg <= 8'h00;
        end else if (hready) begin
            apValid_reg <= hsel && htrans == swf_pkg::HTRANS_NONSEQ;
            apWrite_reg <= hwrite;
            apLow_reg <= haddr[31:8] == 24'h00_0000;
            apAddr_reg <= haddr[7:0];
        end
    end

    // Return format select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fmt_reg <= swf_pkg::FMT_FLOAT;
        end else if (apValid_reg && apWrite_reg && apLow_reg
                     && apAddr_reg == swf_pkg::OFF_CTRL) begin
            fmt_reg <= hwdata[1:0];
        end
    end

    always_comb begin
        hrdata = 32'h0;
        if (apValid_reg && !apWrite_reg && apLow_reg) begin
            if (apAddr_reg == swf_pkg::OFF_CTRL) begin
                hrdata = {30'h0, fmt_reg};
            end else if (apAddr_reg == swf_pkg::OFF_STATUS) begin
                hrdata = {15'h0, state_reg != ST_IDLE, respCount_reg};
            end else if (lutHit) begin
                hrdata = {27'h0, swf_pkg::LUT_N == 0 ? 5'h0 : activeLutVal};
            end
        end
    end

    swf_mask_lut #(.N(swf_pkg::LUT_N)) u_lut (
        .clk(clk_sys),
        .rstn(rstn),
        .wrEn(apValid_reg && apWrite_reg && lutHit),
        .wrIdx(lutRd),
        .wrVal(hwdata[4:0]),
        .rdIdx(lutRd),
        .rdVal(activeLutVal),
        .killMask(killMask_reg),
        .activeMask(activeMask)
    );

    // Request capture
    assign reqReady = rstn && state_reg == ST_IDLE;
    assign accept = reqValid && reqReady;
    assign maskEff = reqChanMask | ((reqLayout == swf_pkg::LAY_UNORM && reqRedGreen)
                     ? swf_pkg::RG_FORCE_MASK : 4'h0);

    always_ff @(posedge clk_sys) begin
        if (accept) begin
            data_reg <= reqData;
            killMask_reg <= reqKillMask;
            exec_reg <= reqExecMask;
            base_reg <= reqDestBase;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lay_reg <= swf_pkg::LAY_SIMD16;
            mask_reg <= 4'h0;
            kill_reg <= 1'b0;
            rg_reg <= 1'b0;
            fmtLatch_reg <= swf_pkg::FMT_FLOAT;
            total_reg <= 4'h0;
        end else if (accept) begin
            lay_reg <= swf_pkg::swf_layout_e'(reqLayout);
            mask_reg <= maskEff;
            kill_reg <= reqKill && (reqLayout == swf_pkg::LAY_SIMD8
                        || reqLayout == swf_pkg::LAY_UNORM);
            rg_reg <= reqRedGreen && reqLayout == swf_pkg::LAY_UNORM;
            fmtLatch_reg <= fmt_reg;
            total_reg <= regCount(reqLayout, maskEff, reqKill && (reqLayout
                         == swf_pkg::LAY_SIMD8 || reqLayout == swf_pkg::LAY_UNORM));
        end
    end

    // Beat content for the current slot
    always_comb begin
        beatData = '0;
        beatEn = 8'h00;
        beatOn = 1'b1;
        chan = slot_reg[2:1];
        half = slot_reg[0];
        slotMax = swf_pkg::SLOT_MAX_PAIR;
        if (state_reg == ST_KILL) begin
            beatEn = swf_pkg::KILL_DW_EN;
            if (lay_reg == swf_pkg::LAY_SIMD8) begin
                beatData[31:0] = {swf_pkg::DISPATCH_MASK, swf_pkg::SIMD8_PAD,
                                  ~killMask_reg[7:0]};
            end else begin
                beatData[31:0] = activeMask;
            end
        end else begin
            case (lay_reg)
                swf_pkg::LAY_SIMD16: begin
                    beatOn = !mask_reg[chan];
                    beatEn = exec_reg[{half, 3'h0} +: 8];
                    for (int d = 0; d < swf_pkg::REG_DW; d++) begin
                        beatData[d * 32 +: 32] = fmtVal(pix32(data_reg, chan,
                            {half, 3'(d)}), fmtLatch_reg);
                    end
                end
                swf_pkg::LAY_SIMD8: begin
                    chan = slot_reg[1:0];
                    slotMax = swf_pkg::SLOT_MAX_SIMD8;
                    beatEn = mask_reg[chan] ? 8'h00 : exec_reg[7:0];
                    for (int d = 0; d < swf_pkg::REG_DW; d++) begin
                        beatData[d * 32 +: 32] = fmtVal(pix32(data_reg, chan,
                            {1'b0, 3'(d)}), fmtLatch_reg);
                    end
                end
                swf_pkg::LAY_SIMD4X2: begin
                    slotMax = swf_pkg::SLOT_MAX_4X2;
                    for (int s = 0; s < 2; s++) begin
                        for (int c = 0; c < 4; c++) begin
                            beatData[(s * 4 + c) * 32 +: 32] = fmtVal(pix32(data_reg,
                                2'(c), 4'(s)), fmtLatch_reg);
                            beatEn[s * 4 + c] = (|exec_reg[s * 4 +: 4]) && !mask_reg[c];
                        end
                    end
                end
                default: begin
                    beatOn = !mask_reg[chan];
                    beatEn = swf_pkg::ALL_DW_EN;
                    for (int d = 0; d < swf_pkg::REG_DW; d++) begin
                        beatData[d * 32 +: 32] = {
                            pix16(data_reg, chan, swf_pkg::PAIR_TABLE[d * 5 +: 5]
                                  + (half ? swf_pkg::HALF_PIX : 5'h0) + 5'h1),
                            pix16(data_reg, chan, swf_pkg::PAIR_TABLE[d * 5 +: 5]
                                  + (half ? swf_pkg::HALF_PIX : 5'h0))};
                    end
                end
            endcase
        end
    end

    assign beat.valid = (state_reg == ST_EMIT && beatOn) || state_reg == ST_KILL;
    assign beat.data = beatData;
    assign beat.dwordEn = beatEn;
    assign beat.layout = lay_reg;
    assign beat.last = outCnt_reg == total_reg - 4'h1;
    assign beat.destReg = (state_reg == ST_KILL && rg_reg)
                          ? base_reg + {4'h0, swf_pkg::RG_KILL_IDX}
                          : base_reg + {4'h0, outCnt_reg};
    assign advance = state_reg == ST_EMIT && (!beatOn || beat.ready);

    // Sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            slot_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    slot_reg <= 3'h0;
                    if (accept) begin
                        state_reg <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (advance) begin
                        slot_reg <= slot_reg + 3'h1;
                        if (slot_reg == slotMax) begin
                            state_reg <= kill_reg ? ST_KILL : ST_IDLE;
                        end
                    end
                end
                ST_KILL: begin
                    if (beat.ready) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Beat and response counters
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            outCnt_reg <= 4'h0;
            respCount_reg <= 16'h0000;
        end else begin
            if (accept) begin
                outCnt_reg <= 4'h0;
            end else if (beat.valid && beat.ready) begin
                outCnt_reg <= outCnt_reg + 4'h1;
            end
            if (beat.valid && beat.ready && beat.last) begin
                respCount_reg <= respCount_reg + 16'h0001;
            end
        end
    end

    swf_beat_buf #(.DEPTH(2), .W(swf_pkg::BEAT_W)) u_buf (
        .clk(clk_sys),
        .rstn(rstn),
        .inp(beat),
        .outValid(wbValid),
        .outReady(wbReady),
        .outWord(outWord)
    );

    assign wbData = outWord[255:0];
    assign wbDwordEn = outWord[263:256];
    assign wbDestReg = outWord[271:264];
    assign wbLast = outWord[272];
    assign wbLayout = outWord[274:273];
endmodule
